// ### src/epc_pkg.sv
package epc_pkg;
  // Data path widths
  localparam int POS_W  = 32;
  localparam int ADDR_W = 6;

  // Device register addresses on the process-data channel
  localparam logic [ADDR_W-1:0] ADDR_POSITION = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_CMP1     = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_CMP2     = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_UPPER    = 6'h03;
  localparam logic [ADDR_W-1:0] ADDR_LOWER    = 6'h04;

  // Device register reset values
  localparam logic [POS_W-1:0] RST_CMP   = 32'h0000_0000;
  localparam logic [POS_W-1:0] RST_UPPER = 32'hFFFF_FFFF;
  localparam logic [POS_W-1:0] RST_LOWER = 32'h0000_0000;

  // Host Avalon byte offsets
  localparam logic [5:0] OFS_CTRL    = 6'h00;
  localparam logic [5:0] OFS_WR_ADDR = 6'h04;
  localparam logic [5:0] OFS_WR_DATA = 6'h08;
  localparam logic [5:0] OFS_RD_ADDR = 6'h0C;
  localparam logic [5:0] OFS_CMD     = 6'h10;
  localparam logic [5:0] OFS_STATUS  = 6'h14;
  localparam logic [5:0] OFS_RD_DATA = 6'h18;
  localparam logic [5:0] OFS_RD_INFO = 6'h1C;
  localparam logic [5:0] OFS_IRQ_ST  = 6'h20;
  localparam logic [5:0] OFS_IRQ_MSK = 6'h24;

  // CTRL field positions
  localparam int CTRL_STOP = 0;
  localparam int CTRL_EN1  = 1;
  localparam int CTRL_CLR1 = 2;
  localparam int CTRL_EN2  = 3;
  localparam int CTRL_CLR2 = 4;
  localparam int CTRL_W    = 5;

  // RD_INFO field positions
  localparam int INFO_ABORT = 8;

  // STATUS register width, bits 0..9 device status then ack, result, busy
  localparam int STAT_W = 13;

  // Interrupt event positions
  localparam int IRQ_WDONE = 0;
  localparam int IRQ_STK1  = 1;
  localparam int IRQ_STK2  = 2;
  localparam int IRQ_UPPER = 3;
  localparam int IRQ_LOWER = 4;
  localparam int IRQ_W     = 5;

  // Host write sequencer, Gray along idle -> request -> release
  typedef enum logic [1:0] {
    EPC_IDLE = 2'b00,
    EPC_REQ  = 2'b01,
    EPC_DROP = 2'b11
  } epc_wseq_t;
endpackage

// ### src/epc_link_if.sv
interface epc_link_if;
  import epc_pkg::*;
  // Host to device, cyclic output image
  logic              stop;
  logic              compare1_enable;
  logic              compare1_flag_clear;
  logic              compare2_enable;
  logic              compare2_flag_clear;
  logic              reg_write_request;
  logic [ADDR_W-1:0] wr_addr;
  logic [POS_W-1:0]  wr_data;
  logic [ADDR_W-1:0] rd_addr;
  // Device to host, cyclic input image
  logic              compare1_equal;
  logic              compare1_match_sticky;
  logic              compare1_at_or_above;
  logic              compare2_equal;
  logic              compare2_match_sticky;
  logic              compare2_at_or_above;
  logic              direction_decreasing;
  logic              direction_increasing;
  logic              upper_limit_exceeded;
  logic              lower_limit_undershot;
  logic              reg_write_acknowledge;
  logic              reg_write_result;
  logic [POS_W-1:0]  rd_data;
  logic [ADDR_W-1:0] rd_addr_echo;
  logic              rd_abort;

  modport dev (
    input  stop, compare1_enable, compare1_flag_clear, compare2_enable, compare2_flag_clear,
    input  reg_write_request, wr_addr, wr_data, rd_addr,
    output compare1_equal, compare1_match_sticky, compare1_at_or_above,
    output compare2_equal, compare2_match_sticky, compare2_at_or_above,
    output direction_decreasing, direction_increasing, upper_limit_exceeded, lower_limit_undershot,
    output reg_write_acknowledge, reg_write_result, rd_data, rd_addr_echo, rd_abort
  );
  modport host (
    output stop, compare1_enable, compare1_flag_clear, compare2_enable, compare2_flag_clear,
    output reg_write_request, wr_addr, wr_data, rd_addr,
    input  compare1_equal, compare1_match_sticky, compare1_at_or_above,
    input  compare2_equal, compare2_match_sticky, compare2_at_or_above,
    input  direction_decreasing, direction_increasing, upper_limit_exceeded, lower_limit_undershot,
    input  reg_write_acknowledge, reg_write_result, rd_data, rd_addr_echo, rd_abort
  );
endinterface

// ### src/epc_device.sv
// Operation
// - Disabled comparator forces its three bits low
// - Enabled comparator bits follow position comparison
// - Flag-clear high clears sticky flag
// - Write request writes addressed register
// - Request low returns acknowledge to zero
// - Accept only with acknowledge low, one per request
// - Write-result bit reports write success
// - Read data carries echo of its address
// - Abort bit marks a read that failed
// - Equality bit high while position equals compare
// - Sticky flag set on match, held until cleared
// - Relation bit high when position at or above
// - Decrease bit high while values fall
// - Increase bit high while values rise
// - Overflow high while position above upper limit
// - Underflow high while position below lower limit
// - Stop input suspends encoder reading
module epc_device
  import epc_pkg::*;
(
  input  wire logic             i_sys_clk,        // Module clock, 100 MHz
  input  wire logic             i_rst,            // Synchronous reset, active high
  input  wire logic [POS_W-1:0] i_position,       // Decoded encoder position
  input  wire logic             i_position_valid, // One-cycle strobe, new position
  output logic                  o_encoder_stop,   // High while encoder reading is held off
  epc_link_if.dev               link              // Process-data channel to the host
);

  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] prev_r;
  logic             sample_r;
  logic             have_prev_r;
  logic [POS_W-1:0] cmp_r [2];
  logic [POS_W-1:0] upper_r;
  logic [POS_W-1:0] lower_r;
  logic [1:0]       en;
  logic [1:0]       clr;
  logic [1:0]       eq_r;
  logic [1:0]       above_r;
  logic [1:0]       sticky_r;
  logic             dec_r;
  logic             inc_r;
  logic             upper_exc_r;
  logic             lower_und_r;
  logic             wr_ack_r;
  logic             wr_result_r;
  logic [POS_W-1:0] rd_data_r;
  logic [ADDR_W-1:0] rd_echo_r;
  logic             rd_abort_r;
  logic             wr_take;

  // Writable register decode, shared by the write result and the read decode
  function automatic logic addr_writable(input logic [ADDR_W-1:0] a);
    return (a == ADDR_CMP1) || (a == ADDR_CMP2) || (a == ADDR_UPPER) || (a == ADDR_LOWER);
  endfunction

  // Readable register decode; position is readable but never writable
  function automatic logic addr_readable(input logic [ADDR_W-1:0] a);
    return (a == ADDR_POSITION) || addr_writable(a);
  endfunction

  assign en  = {link.compare2_enable, link.compare1_enable};
  assign clr = {link.compare2_flag_clear, link.compare1_flag_clear};

  // Stop is passed straight to the encoder reader
  assign o_encoder_stop = link.stop;

  // Position capture; samples arriving while stopped are dropped
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pos_r       <= '0;
      prev_r      <= '0;
      sample_r    <= 1'b0;
      have_prev_r <= 1'b0;
    end else begin
      sample_r <= i_position_valid & ~link.stop;
      if (i_position_valid && !link.stop) begin
        pos_r  <= i_position;
        prev_r <= pos_r;
      end
      if (sample_r) begin
        have_prev_r <= 1'b1;
      end
    end
  end

  // Per-comparator status, one cycle after each new sample
  generate
    for (genvar k = 0; k < 2; k++) begin : g_cmp
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          eq_r[k]    <= 1'b0;
          above_r[k] <= 1'b0;
        end else if (!en[k]) begin
          eq_r[k]    <= 1'b0;
          above_r[k] <= 1'b0;
        end else if (sample_r) begin
          eq_r[k]    <= (pos_r == cmp_r[k]);
          above_r[k] <= (pos_r >= cmp_r[k]);
        end
      end

      // Sticky match; a match in the clearing cycle wins so no hit is lost
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          sticky_r[k] <= 1'b0;
        end else if (!en[k]) begin
          sticky_r[k] <= 1'b0;
        end else if (sample_r && (pos_r == cmp_r[k])) begin
          sticky_r[k] <= 1'b1;
        end else if (clr[k]) begin
          sticky_r[k] <= 1'b0;
        end
      end
    end
  endgenerate

  // Direction from successive samples; the first sample has no history
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dec_r <= 1'b0;
      inc_r <= 1'b0;
    end else if (sample_r) begin
      dec_r <= have_prev_r && (pos_r < prev_r);
      inc_r <= have_prev_r && (pos_r > prev_r);
    end
  end

  // Limit checks against the limit registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      upper_exc_r <= 1'b0;
      lower_und_r <= 1'b0;
    end else if (sample_r) begin
      upper_exc_r <= (pos_r > upper_r);
      lower_und_r <= (pos_r < lower_r);
    end
  end

  // A request is taken only on the rising request, acknowledge low
  assign wr_take = link.reg_write_request & ~wr_ack_r;

  // Acknowledge handshake and write result
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ack_r    <= 1'b0;
      wr_result_r <= 1'b0;
    end else if (!link.reg_write_request) begin
      wr_ack_r <= 1'b0;
    end else if (wr_take) begin
      wr_ack_r    <= 1'b1;
      wr_result_r <= addr_writable(link.wr_addr);
    end
  end

  // Register file; a failed write leaves every register untouched
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmp_r[0] <= RST_CMP;
      cmp_r[1] <= RST_CMP;
      upper_r  <= RST_UPPER;
      lower_r  <= RST_LOWER;
    end else if (wr_take) begin
      unique case (link.wr_addr)
        ADDR_CMP1:  cmp_r[0] <= link.wr_data;
        ADDR_CMP2:  cmp_r[1] <= link.wr_data;
        ADDR_UPPER: upper_r  <= link.wr_data;
        ADDR_LOWER: lower_r  <= link.wr_data;
        default: begin
        end
      endcase
    end
  end

  // Cyclic read: data, address echo and abort always refer to each other
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rd_data_r  <= '0;
      rd_echo_r  <= '0;
      rd_abort_r <= 1'b0;
    end else begin
      rd_echo_r  <= link.rd_addr;
      rd_abort_r <= ~addr_readable(link.rd_addr);
      unique case (link.rd_addr)
        ADDR_POSITION: rd_data_r <= pos_r;
        ADDR_CMP1:     rd_data_r <= cmp_r[0];
        ADDR_CMP2:     rd_data_r <= cmp_r[1];
        ADDR_UPPER:    rd_data_r <= upper_r;
        ADDR_LOWER:    rd_data_r <= lower_r;
        default:       rd_data_r <= '0; // Aborted reads give zero data
      endcase
    end
  end

  // Input image towards the host
  assign link.compare1_equal        = eq_r[0];
  assign link.compare1_match_sticky = sticky_r[0];
  assign link.compare1_at_or_above  = above_r[0];
  assign link.compare2_equal        = eq_r[1];
  assign link.compare2_match_sticky = sticky_r[1];
  assign link.compare2_at_or_above  = above_r[1];
  assign link.direction_decreasing  = dec_r;
  assign link.direction_increasing  = inc_r;
  assign link.upper_limit_exceeded  = upper_exc_r;
  assign link.lower_limit_undershot = lower_und_r;
  assign link.reg_write_acknowledge = wr_ack_r;
  assign link.reg_write_result      = wr_result_r;
  assign link.rd_data               = rd_data_r;
  assign link.rd_addr_echo          = rd_echo_r;
  assign link.rd_abort              = rd_abort_r;

endmodule

// ### src/epc_host.sv
module epc_host
  import epc_pkg::*;
(
  input  wire logic        i_sys_clk,         // Module clock, 100 MHz
  input  wire logic        i_rst,             // Synchronous reset, active high
  input  wire logic [5:0]  i_avs_address,     // Byte address
  input  wire logic        i_avs_read,        // Read request
  input  wire logic        i_avs_write,       // Write request
  input  wire logic [31:0] i_avs_writedata,   // Write data
  output logic      [31:0] o_avs_readdata,    // Read data, registered
  output logic             o_avs_waitrequest, // Stall, first cycle of each access
  output logic             o_irq,             // Level interrupt
  epc_link_if.host         link               // Process-data channel to the device
);

  logic [CTRL_W-1:0] ctrl_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [POS_W-1:0]  wr_data_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic [IRQ_W-1:0]  irq_st_r;
  logic [IRQ_W-1:0]  irq_msk_r;
  logic [IRQ_W-1:0]  ev;
  logic [IRQ_W-1:0]  ev_src;
  logic [IRQ_W-1:0]  ev_src_r;
  logic [31:0]       rdata_r;
  logic              served_r;
  logic              acc;
  logic              wr_acc;
  logic              rd_acc;
  logic              wdone;
  epc_wseq_t         wseq_r;
  logic [STAT_W-1:0] status;

  // One wait cycle per access gives time to register the read data
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~served_r;
  assign acc    = (i_avs_read | i_avs_write) & served_r;
  assign wr_acc = acc & i_avs_write;
  assign rd_acc = acc & i_avs_read;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      served_r <= 1'b0;
    end else begin
      served_r <= (i_avs_read | i_avs_write) & ~served_r;
    end
  end

  assign status = {wseq_r != EPC_IDLE, link.reg_write_result, link.reg_write_acknowledge,
                   link.lower_limit_undershot, link.upper_limit_exceeded,
                   link.direction_increasing, link.direction_decreasing,
                   link.compare2_at_or_above, link.compare2_match_sticky, link.compare2_equal,
                   link.compare1_at_or_above, link.compare1_match_sticky, link.compare1_equal};

  // Control registers written by software
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_r    <= '0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
      rd_addr_r <= '0;
      irq_msk_r <= '0;
    end else if (wr_acc) begin
      unique case (i_avs_address)
        OFS_CTRL:    ctrl_r    <= i_avs_writedata[CTRL_W-1:0];
        OFS_WR_ADDR: wr_addr_r <= i_avs_writedata[ADDR_W-1:0];
        OFS_WR_DATA: wr_data_r <= i_avs_writedata;
        OFS_RD_ADDR: rd_addr_r <= i_avs_writedata[ADDR_W-1:0];
        OFS_IRQ_MSK: irq_msk_r <= i_avs_writedata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read data latched in the wait cycle; unmapped offsets read zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_r <= '0;
    end else if (i_avs_read && !served_r) begin
      unique case (i_avs_address)
        OFS_CTRL:    rdata_r <= 32'(ctrl_r);
        OFS_WR_ADDR: rdata_r <= 32'(wr_addr_r);
        OFS_WR_DATA: rdata_r <= wr_data_r;
        OFS_RD_ADDR: rdata_r <= 32'(rd_addr_r);
        OFS_STATUS:  rdata_r <= 32'(status);
        OFS_RD_DATA: rdata_r <= link.rd_data;
        OFS_RD_INFO: rdata_r <= 32'({link.rd_abort, 2'h0, link.rd_addr_echo});
        OFS_IRQ_ST:  rdata_r <= 32'(irq_st_r);
        OFS_IRQ_MSK: rdata_r <= 32'(irq_msk_r);
        default:     rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign o_avs_readdata = rdata_r;

  // Write sequencer: raise request, wait acknowledge, drop, wait release
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wseq_r <= EPC_IDLE;
    end else begin
      unique case (wseq_r)
        EPC_IDLE: if (wr_acc && i_avs_address == OFS_CMD && i_avs_writedata[0]) wseq_r <= EPC_REQ;
        EPC_REQ:  if (link.reg_write_acknowledge) wseq_r <= EPC_DROP;
        EPC_DROP: if (!link.reg_write_acknowledge) wseq_r <= EPC_IDLE;
        default:  wseq_r <= EPC_IDLE; // Unused code falls back to idle
      endcase
    end
  end
  assign wdone = (wseq_r == EPC_DROP) & ~link.reg_write_acknowledge;

  // Rising edges of the sticky match flags and limit bits become events
  assign ev_src = {link.lower_limit_undershot, link.upper_limit_exceeded,
                   link.compare2_match_sticky, link.compare1_match_sticky, 1'b0};
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ev_src_r <= '0;
    end else begin
      ev_src_r <= ev_src;
    end
  end
  assign ev = (ev_src & ~ev_src_r) | {{(IRQ_W-1){1'b0}}, wdone};

  // Sticky interrupt status; a read clears only the bits it returned,
  // so an event landing between latch and hand-over is not lost
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_st_r <= '0;
    end else if (rd_acc && i_avs_address == OFS_IRQ_ST) begin
      irq_st_r <= (irq_st_r & ~rdata_r[IRQ_W-1:0]) | ev;
    end else begin
      irq_st_r <= irq_st_r | ev;
    end
  end
  assign o_irq = |(irq_st_r & irq_msk_r);

  // Output image towards the device
  assign link.stop                = ctrl_r[CTRL_STOP];
  assign link.compare1_enable     = ctrl_r[CTRL_EN1];
  assign link.compare1_flag_clear = ctrl_r[CTRL_CLR1];
  assign link.compare2_enable     = ctrl_r[CTRL_EN2];
  assign link.compare2_flag_clear = ctrl_r[CTRL_CLR2];
  assign link.reg_write_request   = (wseq_r == EPC_REQ);
  assign link.wr_addr             = wr_addr_r;
  assign link.wr_data             = wr_data_r;
  assign link.rd_addr             = rd_addr_r; // Read data trusted only with abort low

endmodule

// ### sim/epc_link_props.sv
module epc_link_props
  import epc_pkg::*;
(
  input logic              i_sys_clk,             // Module clock
  input logic              i_rst,                 // Sync reset
  input logic              compare1_enable,       // Host enable 1
  input logic              compare1_flag_clear,   // Host clear 1
  input logic              compare2_enable,       // Host enable 2
  input logic              compare1_equal,        // Device eq 1
  input logic              compare1_match_sticky, // Device sticky 1
  input logic              compare1_at_or_above,  // Device relation 1
  input logic              compare2_equal,        // Device eq 2
  input logic              compare2_match_sticky, // Device sticky 2
  input logic              compare2_at_or_above,  // Device relation 2
  input logic              direction_decreasing,  // Falling values
  input logic              direction_increasing,  // Rising values
  input logic              reg_write_request,     // Host write request
  input logic              reg_write_acknowledge, // Device write ack
  input logic              reg_write_result,      // Device write result
  input logic [ADDR_W-1:0] rd_addr,               // Host read address
  input logic [POS_W-1:0]  rd_data,               // Device read data
  input logic [ADDR_W-1:0] rd_addr_echo,          // Device address echo
  input logic              rd_abort               // Device read abort
);
  // One clock domain, so one clocking and one disable for all
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  // Write handshake and flag-clear steps
  sequence s_take;
    reg_write_request && !reg_write_acknowledge;
  endsequence
  sequence s_clr_held;
    compare1_flag_clear ##1 compare1_flag_clear;
  endsequence

  property p_ack_rise;
    s_take |=> reg_write_acknowledge;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack missing after take");
  property p_ack_hold;
    reg_write_acknowledge && reg_write_request |=> reg_write_acknowledge;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped under request");
  property p_ack_drop;
    reg_write_acknowledge && !reg_write_request |=> !reg_write_acknowledge;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack stuck after release");
  property p_result;
    !(reg_write_request && !reg_write_acknowledge) |=> $stable(reg_write_result);
  endproperty
  a_result: assert property (p_result) else $error("result moved without take");
  property p_off1;
    !compare1_enable |=> !(compare1_equal || compare1_match_sticky || compare1_at_or_above);
  endproperty
  a_off1: assert property (p_off1) else $error("disabled comparator 1 active");
  property p_off2;
    !compare2_enable |=> !(compare2_equal || compare2_match_sticky || compare2_at_or_above);
  endproperty
  a_off2: assert property (p_off2) else $error("disabled comparator 2 active");
  property p_eq_above;
    (!compare1_equal || compare1_at_or_above) && (!compare2_equal || compare2_at_or_above);
  endproperty
  a_eq_above: assert property (p_eq_above) else $error("equal but below");
  property p_keep;
    compare1_match_sticky && compare1_enable && !compare1_flag_clear |=> compare1_match_sticky;
  endproperty
  a_keep: assert property (p_keep) else $error("sticky lost without clear");
  property p_clear;
    s_clr_held |=> !compare1_match_sticky || compare1_equal;
  endproperty
  a_clear: assert property (p_clear) else $error("sticky survived clear");
  property p_dir;
    !(direction_decreasing && direction_increasing);
  endproperty
  a_dir: assert property (p_dir) else $error("both directions set");
  property p_echo;
    1'h1 |=> rd_addr_echo == $past(rd_addr) && rd_abort == ($past(rd_addr) > ADDR_LOWER);
  endproperty
  a_echo: assert property (p_echo) else $error("echo or abort wrong");
  property p_abort_data;
    rd_abort |-> rd_data == '0;
  endproperty
  a_abort_data: assert property (p_abort_data) else $error("aborted read carries data");
endmodule

// ### sim/tb_encoder_position_compare_regaccess.sv
module tb_encoder_position_compare_regaccess
  import epc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [5:0] a; logic [31:0] d; logic ok; logic [31:0] r0; logic [31:0] rb; logic ab;} epc_row_t;
  logic        i_sys_clk = 1'h0;
  logic        i_rst = 1'h1;
  logic [5:0]  av_addr = '0;
  logic        av_rd = 1'h0;
  logic        av_wr = 1'h0;
  logic [31:0] av_wdata = '0;
  logic [31:0] position = '0;
  logic        position_valid = 1'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic        enc_stop;
  logic [31:0] rv;
  logic [31:0] prev;
  logic [9:0]  es = '0;
  logic        en1 = 1'h1, en2 = 1'h1, stk1 = 1'h0, stk2 = 1'h0, first = 1'h1;
  int          miscompares = 0;
  int          samples_checked = 0;
  epc_row_t    rows[7] = '{'{6'h01, 32'h64, 1'h1, 32'h0, 32'h64, 1'h0}, '{6'h02, 32'hC8, 1'h1, 32'h0, 32'hC8, 1'h0},
    '{6'h03, 32'h12C, 1'h1, 32'hFFFFFFFF, 32'h12C, 1'h0}, '{6'h04, 32'h32, 1'h1, 32'h0, 32'h32, 1'h0},
    '{6'h00, 32'h7, 1'h0, 32'h0, 32'h0, 1'h0}, '{6'h05, 32'h9, 1'h0, 32'h0, 32'h0, 1'h1},
    '{6'h3F, 32'h9, 1'h0, 32'h0, 32'h0, 1'h1}};
  logic [31:0] pos_seq[7] = '{32'hA, 32'h64, 32'h96, 32'hC8, 32'h190, 32'h190, 32'h78};

  // Free-running 100 MHz clock
  always #5 i_sys_clk = ~i_sys_clk;

  // Both ends joined by the link
  epc_link_if link();
  epc_device epc_device_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_position(position),
    .i_position_valid(position_valid), .o_encoder_stop(enc_stop), .link(link));
  epc_host epc_host_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_address(av_addr), .i_avs_read(av_rd),
    .i_avs_write(av_wr), .i_avs_writedata(av_wdata), .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest),
    .o_irq(irq), .link(link));
  epc_link_props epc_link_props_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .compare1_enable(link.compare1_enable), .compare1_flag_clear(link.compare1_flag_clear),
    .compare2_enable(link.compare2_enable), .compare1_equal(link.compare1_equal),
    .compare1_match_sticky(link.compare1_match_sticky), .compare1_at_or_above(link.compare1_at_or_above),
    .compare2_equal(link.compare2_equal), .compare2_match_sticky(link.compare2_match_sticky),
    .compare2_at_or_above(link.compare2_at_or_above), .direction_decreasing(link.direction_decreasing),
    .direction_increasing(link.direction_increasing), .reg_write_request(link.reg_write_request),
    .reg_write_acknowledge(link.reg_write_acknowledge), .reg_write_result(link.reg_write_result),
    .rd_addr(link.rd_addr), .rd_data(link.rd_data), .rd_addr_echo(link.rd_addr_echo), .rd_abort(link.rd_abort));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    av_addr <= a;
    av_wr <= wr;
    av_rd <= !wr;
    av_wdata <= d;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 50);
    rv = readdata;
    av_rd <= 1'h0;
    av_wr <= 1'h0;
    if (n >= 50) check("bus wait", 32'h1, 32'h0);
  endtask

  task automatic rd(input logic [5:0] a);
    bus(1'h0, a, 32'h0);
  endtask

  // Device write through the host sequencer, polled until idle
  task automatic dev_wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'h1, OFS_WR_ADDR, {26'h0, a});
    bus(1'h1, OFS_WR_DATA, d);
    bus(1'h1, OFS_CMD, 32'h1);
    repeat (20) begin
      rd(OFS_STATUS);
      if (rv[12] === 1'h0) break;
    end
  endtask

  // One encoder sample; expectation built from the comparison rules
  task automatic sample(input logic [31:0] p);
    @(posedge i_sys_clk);
    position <= p;
    position_valid <= 1'h1;
    @(posedge i_sys_clk);
    position_valid <= 1'h0;
    repeat (3) @(posedge i_sys_clk);
    es[0] = en1 && p == 32'h64;
    es[2] = en1 && p >= 32'h64;
    es[3] = en2 && p == 32'hC8;
    es[5] = en2 && p >= 32'hC8;
    stk1 = en1 && (stk1 || es[0]);
    stk2 = en2 && (stk2 || es[3]);
    es[1] = stk1;
    es[4] = stk2;
    es[6] = !first && p < prev;
    es[7] = !first && p > prev;
    es[8] = p > 32'h12C;
    es[9] = p < 32'h32;
    prev = p;
    first = 1'h0;
    rd(OFS_STATUS);
    check("status", {22'h0, rv[9:0]}, {22'h0, es});
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard, well past the expected run length
  initial begin
    #100us;
    miscompares++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    check("irq after reset", {31'h0, irq}, 32'h0);
    foreach (rows[i]) begin
      bus(1'h1, OFS_RD_ADDR, {26'h0, rows[i].a});
      rd(OFS_RD_DATA);
      check("reset value", rv, rows[i].r0);
      dev_wr(rows[i].a, rows[i].d);
      check("write result", {29'h0, rv[12:10]}, {29'h0, 1'h0, rows[i].ok, 1'h0});
      rd(OFS_RD_DATA);
      check("readback", rv, rows[i].rb);
      rd(OFS_RD_INFO);
      check("read info", rv, {23'h0, rows[i].ab, 2'h0, rows[i].a});
    end
    // Interrupt: write-done pending, masked, unmasked, cleared by read
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'h1, OFS_IRQ_MSK, 32'h1);
    @(posedge i_sys_clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    rd(OFS_IRQ_ST);
    check("irq status", rv, 32'h1);
    @(posedge i_sys_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    bus(1'h1, OFS_IRQ_MSK, 32'h2);
    bus(1'h1, OFS_CTRL, 32'hA);
    foreach (pos_seq[i]) sample(pos_seq[i]);
    check("irq sticky", {31'h0, irq}, 32'h1);
    rd(OFS_IRQ_ST);
    check("irq events", rv, 32'h1E);
    // Clear of flag 1 only, flag 2 untouched
    bus(1'h1, OFS_CTRL, 32'hE);
    rd(OFS_STATUS);
    check("clear one", {30'h0, rv[4], rv[1]}, 32'h2);
    // Clear of flag 2, both comparators kept enabled
    bus(1'h1, OFS_CTRL, 32'h1A);
    rd(OFS_STATUS);
    check("clear two", {30'h0, rv[4], rv[1]}, 32'h0);
    // Comparator 2 disabled forces its bits low at once
    bus(1'h1, OFS_CTRL, 32'h2);
    rd(OFS_STATUS);
    check("disable two", {26'h0, rv[5:0]}, 32'h4);
    // Stop: samples are ignored
    bus(1'h1, OFS_CTRL, 32'h3);
    bus(1'h1, OFS_RD_ADDR, 32'h0);
    check("stop out", {31'h0, enc_stop}, 32'h1);
    @(posedge i_sys_clk);
    position <= 32'h5;
    position_valid <= 1'h1;
    @(posedge i_sys_clk);
    position_valid <= 1'h0;
    rd(OFS_RD_DATA);
    check("held position", rv, 32'h78);
    bus(1'h1, OFS_CTRL, 32'h2);
    @(posedge i_sys_clk);
    check("stop released", {31'h0, enc_stop}, 32'h0);
    rd(6'h28);
    check("unmapped read", rv, 32'h0);
    rd(OFS_IRQ_MSK);
    check("mask readback", rv, 32'h2);
    // Mid-run reset returns both ends to their reset state
    i_rst <= 1'h1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    rd(OFS_IRQ_MSK);
    check("mask after reset", rv, 32'h0);
    rd(OFS_RD_DATA);
    check("position after reset", rv, 32'h0);
    check("irq after mid reset", {31'h0, irq}, 32'h0);
    final_report();
  end
endmodule
